// >>> design/sece_defines.svh
`ifndef SECE_DEFINES_SVH
`define SECE_DEFINES_SVH

// ----------------------------------------------------------------------------
// Array geometry
// ----------------------------------------------------------------------------
`define SECE_ADDR_W 9
`define SECE_MEM_BYTES 512
`define SECE_PAGE_W 5
`define SECE_PAGE_BYTES 32

// ----------------------------------------------------------------------------
// Opcode fields: upper nibble is zero, bit 3 is don't care or address bit 8
// ----------------------------------------------------------------------------
`define SECE_OP_HI_ZERO 4'h0
`define SECE_OP_A8_BIT 3
`define SECE_OP_SET_LATCH 3'h6
`define SECE_OP_CLR_LATCH 3'h4
`define SECE_OP_STAT_RD 3'h5
`define SECE_OP_STAT_WR 3'h1
`define SECE_OP_ARR_RD 3'h3
`define SECE_OP_ARR_WR 3'h2

// ----------------------------------------------------------------------------
// Status byte layout and protect encodings
// ----------------------------------------------------------------------------
`define SECE_ST_BUSY_BIT 0
`define SECE_ST_WEL_BIT 1
`define SECE_ST_BP_LO_BIT 2
`define SECE_ST_BP_HI_BIT 3
`define SECE_ST_RESET 8'h00
`define SECE_BP_NONE 2'h0
`define SECE_BP_QUARTER 2'h1
`define SECE_BP_HALF 2'h2
`define SECE_BP_ALL 2'h3

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define SECE_SYS_CLK_PERIOD_NS 4
`define SECE_WRITE_CYCLE_TIME_NS 5000000
`define SECE_WRITE_CYCLES (`SECE_WRITE_CYCLE_TIME_NS / `SECE_SYS_CLK_PERIOD_NS)
`define SECE_WC_CNT_W 21

`endif

// >>> design/sece_pkg.sv
package sece_pkg;

  typedef enum logic [2:0] {
    CMD_NONE = 3'h0,
    CMD_SET_LATCH = 3'h1,
    CMD_CLR_LATCH = 3'h2,
    CMD_STAT_RD = 3'h3,
    CMD_STAT_WR = 3'h4,
    CMD_ARR_RD = 3'h5,
    CMD_ARR_WR = 3'h6,
    CMD_BAD = 3'h7
  } sece_cmd_e;

  typedef enum logic [2:0] {
    L_OPCODE = 3'h0,
    L_ADDR = 3'h1,
    L_DATA = 3'h2,
    L_STAT_OUT = 3'h3,
    L_ARR_OUT = 3'h4,
    L_WAIT = 3'h5,
    L_DEAD = 3'h6
  } sece_lstate_e;

  typedef enum logic [1:0] {
    W_IDLE = 2'h0,
    W_COPY = 2'h1,
    W_ARRAY = 2'h2,
    W_STATUS = 2'h3
  } sece_wstate_e;

endpackage : sece_pkg

// >>> design/sece_wc_if.sv
`timescale 1ns/1ns
`include "sece_defines.svh"

interface sece_wc_if;
  logic start_status;
  logic start_array;
  logic copy_we;
  logic [`SECE_PAGE_W-1:0] idx;
  logic busy;
  logic done_status;
  logic done_array;

  modport engine (
    output start_status,
    output start_array,
    input copy_we,
    input idx,
    input busy,
    input done_status,
    input done_array
  );

  modport cycle (
    input start_status,
    input start_array,
    output copy_we,
    output idx,
    output busy,
    output done_status,
    output done_array
  );
endinterface : sece_wc_if

// >>> design/sece_wcycle.sv
`timescale 1ns/1ns
`include "sece_defines.svh"

module sece_wcycle #(
  parameter int unsigned WRITE_CYCLES = `SECE_WRITE_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  sece_wc_if.cycle wc
);
  import sece_pkg::*;

  localparam logic [`SECE_WC_CNT_W-1:0] LAST_CNT = `SECE_WC_CNT_W'(WRITE_CYCLES - 1);
  localparam logic [`SECE_PAGE_W-1:0] LAST_IDX = `SECE_PAGE_W'(`SECE_PAGE_BYTES - 1);

  sece_wstate_e state_r;
  logic [`SECE_WC_CNT_W-1:0] cnt_r;
  logic [`SECE_PAGE_W-1:0] idx_r;
  logic cnt_end;

  assign cnt_end = (cnt_r == LAST_CNT);
  assign wc.busy = (state_r != W_IDLE);
  assign wc.copy_we = (state_r == W_COPY);
  assign wc.idx = idx_r;
  // Completion is flagged in the last cycle before busy drops, so the latch and
  // protect bits change on the very edge where the status shows idle.
  assign wc.done_array = (state_r == W_ARRAY) && cnt_end;
  assign wc.done_status = (state_r == W_STATUS) && cnt_end;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= W_IDLE;
    end else begin
      case (state_r)
        W_IDLE: begin
          if (wc.start_array) begin
            state_r <= W_COPY;
          end else if (wc.start_status) begin
            state_r <= W_STATUS;
          end
        end
        W_COPY: begin
          if (idx_r == LAST_IDX) begin
            state_r <= W_ARRAY;
          end
        end
        W_ARRAY, W_STATUS: begin
          if (cnt_end) begin
            state_r <= W_IDLE;
          end
        end
        default: begin
          state_r <= W_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      idx_r <= '0;
    end else begin
      idx_r <= (state_r == W_COPY) ? idx_r + `SECE_PAGE_W'(1) : '0;
      cnt_r <= (state_r == W_ARRAY || state_r == W_STATUS) ? cnt_r + `SECE_WC_CNT_W'(1) : '0;
    end
  end
endmodule : sece_wcycle

// >>> design/sece_engine.sv
`timescale 1ns/1ns
`include "sece_defines.svh"

// Functional notes
// - Opcode is first byte; latch set x110, latch clear x100, status read x101.
// - Array read A011, array write A010; opcode bit 3 carries address bit 8.
// - Unknown opcode makes the device ignore the rest until next select.
// - Every write needs a prior latch set; only that command sets the latch.
// - Latch set and clear act only when select rises, nothing before.
// - Latch clears at power-up, clear command, write completion, protect pin low.
// - Status read accepted anytime, repeats the current status while selected.
// - Busy bit shows a running write cycle; cleared latch refuses writes.
// - Status write changes only the protect bits; bits 7 to 4 read zero.
// - Status write runs only if select rises right after the eighth data bit.
// - Valid status write starts a timed cycle; completion clears busy and latch.
// - Protection keeps old protect bits until the status cycle completes.
// - Protect pin low ignores writes, holds latch clear, never aborts a cycle.
// - Array read loads address, outputs bytes, increments while selected.
// - Read address wraps from the top of the array to zero.
// - Array read during a running write cycle is refused.
// - Array address is nine bits; bit 8 is unused on the smaller part.
// - Array write commits only when select rises at a data byte boundary.
// - Extra data bytes advance the low address bits and wrap inside the page.
// - Array write refused without latch, while busy, on protected page, or pin low.
// - Protect bits 00 none, 01 upper quarter, 10 upper half, 11 whole array.
// - Input sampled on clock rise, output changes after fall, floats when deselected.
// - No command decodes until select has been seen high once after power-up.
// - Pause pin low suspends the transfer and floats the output.

module sece_engine #(
  parameter int unsigned WRITE_CYCLES = `SECE_WRITE_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic serial_clock,
  input wire logic select_n,
  input wire logic serial_in,
  input wire logic pause_n,
  input wire logic write_protect_n,
  output logic serial_out,
  output logic serial_out_oe
);
  import sece_pkg::*;

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  logic frame_rst_n;
  logic [2:0] bit_cnt_r;
  logic started_r;
  logic [6:0] shift_r;
  logic [7:0] rx_byte;
  logic byte_end;
  sece_lstate_e lstate_r;
  sece_lstate_e lstate_nxt;
  sece_cmd_e op_kind;
  sece_cmd_e res_kind_r;
  logic res_done_r;
  logic tag_r;
  logic [7:0] res_stat_r;
  logic [`SECE_ADDR_W-1:0] addr_r;
  logic [`SECE_ADDR_W-1:0] rd_addr;
  logic [7:0] rd_data;
  logic [7:0] tx_r;
  logic out_bit_r;
  logic out_on_r;
  logic [7:0] status_m_r;
  logic [7:0] status_s_r;
  logic armed_m_r;
  logic armed_s_r;
  logic busy_s;
  logic [7:0] page_buf [0:`SECE_PAGE_BYTES-1];
  logic [`SECE_PAGE_BYTES-1:0] page_mask_r;
  logic [7:0] mem [0:`SECE_MEM_BYTES-1];

  logic sel_m_r;
  logic sel_s_r;
  logic sel_d_r;
  logic wp_m_r;
  logic wp_s_r;
  logic armed_r;
  logic seen_tag_r;
  logic new_frame;
  logic wel_r;
  logic [1:0] bp_r;
  logic [1:0] bp_new_r;
  logic [`SECE_ADDR_W-`SECE_PAGE_W-1:0] wr_page_hi;
  logic page_locked;
  logic accept_status;
  logic accept_array;
  logic [7:0] status_byte;

  sece_wc_if wc ();

  sece_wcycle #(
    .WRITE_CYCLES(WRITE_CYCLES)
  ) u_wcycle (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .wc(wc.cycle)
  );

  // --------------------------------------------------------------------------
  // Link domain: bit framing
  // --------------------------------------------------------------------------
  // Raising select ends the frame asynchronously, since the serial clock is
  // not guaranteed to run again after the last bit.
  assign frame_rst_n = rst_n & ~select_n;
  assign rx_byte = {shift_r, serial_in};
  assign byte_end = (bit_cnt_r == 3'h7);
  assign busy_s = status_s_r[`SECE_ST_BUSY_BIT];

  always_ff @(posedge serial_clock or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      bit_cnt_r <= 3'h0;
      shift_r <= 7'h00;
      started_r <= 1'b0;
      lstate_r <= L_OPCODE;
    end else if (pause_n) begin
      started_r <= 1'b1;
      bit_cnt_r <= bit_cnt_r + 3'h1;
      shift_r <= rx_byte[6:0];
      if (byte_end) begin
        lstate_r <= lstate_nxt;
      end
    end
  end

  always_comb begin
    op_kind = CMD_BAD;
    if (rx_byte[7:4] == `SECE_OP_HI_ZERO) begin
      case (rx_byte[2:0])
        `SECE_OP_SET_LATCH: op_kind = CMD_SET_LATCH;
        `SECE_OP_CLR_LATCH: op_kind = CMD_CLR_LATCH;
        `SECE_OP_STAT_RD: op_kind = CMD_STAT_RD;
        `SECE_OP_STAT_WR: op_kind = CMD_STAT_WR;
        `SECE_OP_ARR_RD: op_kind = CMD_ARR_RD;
        `SECE_OP_ARR_WR: op_kind = CMD_ARR_WR;
        default: op_kind = CMD_BAD;
      endcase
    end
  end

  // Busy and armed are checked on the eighth edge, by which time their
  // synchronisers have been clocked by this frame and no longer hold stale data.
  always_comb begin
    lstate_nxt = lstate_r;
    case (lstate_r)
      L_OPCODE: begin
        if (!armed_s_r) begin
          lstate_nxt = L_DEAD;
        end else begin
          case (op_kind)
            CMD_SET_LATCH: lstate_nxt = L_WAIT;
            CMD_CLR_LATCH: lstate_nxt = L_WAIT;
            CMD_STAT_RD: lstate_nxt = L_STAT_OUT;
            CMD_STAT_WR: lstate_nxt = L_DATA;
            CMD_ARR_RD: lstate_nxt = busy_s ? L_DEAD : L_ADDR;
            CMD_ARR_WR: lstate_nxt = busy_s ? L_DEAD : L_ADDR;
            default: lstate_nxt = L_DEAD;
          endcase
        end
      end
      L_ADDR: begin
        lstate_nxt = (res_kind_r == CMD_ARR_RD) ? L_ARR_OUT : L_DATA;
      end
      L_DATA: begin
        lstate_nxt = (res_kind_r == CMD_STAT_WR) ? L_WAIT : L_DATA;
      end
      default: begin
        lstate_nxt = lstate_r;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Link domain: frame results held for the system side
  // --------------------------------------------------------------------------
  // These survive the rise of select; the system side reads them only after
  // it has seen select high through its synchroniser, when no clock runs.
  always_ff @(posedge serial_clock or negedge rst_n) begin
    if (!rst_n) begin
      tag_r <= 1'b0;
      res_kind_r <= CMD_NONE;
      res_done_r <= 1'b0;
      res_stat_r <= 8'h00;
      page_mask_r <= '0;
    end else if (pause_n) begin
      if (!started_r) begin
        tag_r <= ~tag_r;
        res_kind_r <= CMD_NONE;
      end
      res_done_r <= 1'b0;
      if (byte_end) begin
        case (lstate_r)
          L_OPCODE: begin
            res_kind_r <= (lstate_nxt == L_DEAD) ? CMD_BAD : op_kind;
          end
          L_ADDR: begin
            page_mask_r <= '0;
          end
          L_DATA: begin
            res_done_r <= 1'b1;
            if (res_kind_r == CMD_STAT_WR) begin
              res_stat_r <= rx_byte;
            end else begin
              page_mask_r[addr_r[`SECE_PAGE_W-1:0]] <= 1'b1;
            end
          end
          default: begin
            res_kind_r <= res_kind_r;
          end
        endcase
      end
    end
  end

  // A late byte overwrites the one buffered at the same page offset.
  always_ff @(posedge serial_clock) begin
    if (pause_n && byte_end && lstate_r == L_DATA && res_kind_r == CMD_ARR_WR) begin
      page_buf[addr_r[`SECE_PAGE_W-1:0]] <= rx_byte;
    end
  end

  // --------------------------------------------------------------------------
  // Link domain: address counter and transmit path
  // --------------------------------------------------------------------------
  assign rd_addr = (lstate_r == L_ADDR) ? {addr_r[`SECE_ADDR_W-1], rx_byte} : addr_r;

  always_ff @(posedge serial_clock or negedge rst_n) begin
    if (!rst_n) begin
      addr_r <= '0;
    end else if (pause_n && byte_end) begin
      case (lstate_r)
        L_OPCODE: begin
          addr_r[`SECE_ADDR_W-1] <= rx_byte[`SECE_OP_A8_BIT];
        end
        L_ADDR: begin
          addr_r <= (res_kind_r == CMD_ARR_RD) ? rd_addr + `SECE_ADDR_W'(1) : rd_addr;
        end
        L_ARR_OUT: begin
          addr_r <= addr_r + `SECE_ADDR_W'(1);
        end
        L_DATA: begin
          addr_r[`SECE_PAGE_W-1:0] <= addr_r[`SECE_PAGE_W-1:0] + `SECE_PAGE_W'(1);
        end
        default: begin
          addr_r <= addr_r;
        end
      endcase
    end
  end

  // The array is read without a clock crossing: reads are refused while a
  // write cycle runs, so the addressed word cannot change under the reader.
  assign rd_data = mem[rd_addr];

  always_ff @(posedge serial_clock or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      tx_r <= 8'h00;
    end else if (pause_n && byte_end) begin
      case (lstate_r)
        L_OPCODE, L_STAT_OUT: tx_r <= status_s_r;
        L_ADDR, L_ARR_OUT: tx_r <= rd_data;
        default: tx_r <= tx_r;
      endcase
    end
  end

  always_ff @(negedge serial_clock or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      out_bit_r <= 1'b0;
      out_on_r <= 1'b0;
    end else if (pause_n) begin
      out_on_r <= (lstate_r == L_STAT_OUT) || (lstate_r == L_ARR_OUT);
      out_bit_r <= tx_r[3'h7 - bit_cnt_r];
    end
  end

  assign serial_out = out_bit_r;
  assign serial_out_oe = ~select_n & pause_n & out_on_r;

  // Status bits change slowly relative to a byte, so a per-bit level
  // synchroniser is enough; a byte may mix old and new bits only at an edge.
  always_ff @(posedge serial_clock or negedge rst_n) begin
    if (!rst_n) begin
      status_m_r <= `SECE_ST_RESET;
      status_s_r <= `SECE_ST_RESET;
      armed_m_r <= 1'b0;
      armed_s_r <= 1'b0;
    end else begin
      status_m_r <= status_byte;
      status_s_r <= status_m_r;
      armed_m_r <= armed_r;
      armed_s_r <= armed_m_r;
    end
  end

  // --------------------------------------------------------------------------
  // System domain: pin synchronisers and frame end detection
  // --------------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      // Reset low so that arming needs a real high sample of select; the tag
      // comparison keeps the edge this makes from committing anything.
      sel_m_r <= 1'b0;
      sel_s_r <= 1'b0;
      sel_d_r <= 1'b0;
      wp_m_r <= 1'b0;
      wp_s_r <= 1'b0;
    end else begin
      sel_m_r <= select_n;
      sel_s_r <= sel_m_r;
      sel_d_r <= sel_s_r;
      wp_m_r <= write_protect_n;
      wp_s_r <= wp_m_r;
    end
  end

  // Armed only once select is seen high, so a frame already running at
  // release of reset never decodes.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      armed_r <= 1'b0;
      seen_tag_r <= 1'b0;
    end else begin
      if (sel_s_r) begin
        armed_r <= 1'b1;
      end
      if (sel_s_r && !sel_d_r) begin
        seen_tag_r <= tag_r;
      end
    end
  end

  // A frame with no clock edge keeps the old tag and so replays nothing.
  assign new_frame = sel_s_r & ~sel_d_r & (tag_r != seen_tag_r);

  // --------------------------------------------------------------------------
  // System domain: command commit
  // --------------------------------------------------------------------------
  assign wr_page_hi = addr_r[`SECE_ADDR_W-1:`SECE_ADDR_W-`SECE_PAGE_W+1];

  always_comb begin
    case (bp_r)
      `SECE_BP_NONE: page_locked = 1'b0;
      `SECE_BP_QUARTER: page_locked = (wr_page_hi[3:2] == 2'h3);
      `SECE_BP_HALF: page_locked = wr_page_hi[3];
      `SECE_BP_ALL: page_locked = 1'b1;
      default: page_locked = 1'b1;
    endcase
  end

  assign accept_status = new_frame && res_kind_r == CMD_STAT_WR && res_done_r
                         && wel_r && !wc.busy && wp_s_r;
  assign accept_array = new_frame && res_kind_r == CMD_ARR_WR && res_done_r && wel_r
                        && !wc.busy && wp_s_r && !page_locked && (|page_mask_r);
  assign wc.start_status = accept_status;
  assign wc.start_array = accept_array;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wel_r <= 1'b0;
    end else if (!wp_s_r) begin
      wel_r <= 1'b0;
    end else if (wc.done_status || wc.done_array) begin
      wel_r <= 1'b0;
    end else if (new_frame && res_kind_r == CMD_CLR_LATCH) begin
      wel_r <= 1'b0;
    end else if (new_frame && res_kind_r == CMD_SET_LATCH) begin
      wel_r <= 1'b1;
    end
  end

  // New protect bits wait in a shadow until the cycle completes.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bp_r <= `SECE_BP_NONE;
      bp_new_r <= `SECE_BP_NONE;
    end else begin
      if (accept_status) begin
        bp_new_r <= {res_stat_r[`SECE_ST_BP_HI_BIT], res_stat_r[`SECE_ST_BP_LO_BIT]};
      end
      if (wc.done_status) begin
        bp_r <= bp_new_r;
      end
    end
  end

  always_comb begin
    status_byte = `SECE_ST_RESET;
    status_byte[`SECE_ST_BUSY_BIT] = wc.busy;
    status_byte[`SECE_ST_WEL_BIT] = wel_r;
    status_byte[`SECE_ST_BP_LO_BIT] = bp_r[0];
    status_byte[`SECE_ST_BP_HI_BIT] = bp_r[1];
  end

  // --------------------------------------------------------------------------
  // System domain: array storage
  // --------------------------------------------------------------------------
  // The page buffer is read here without a crossing; it is stable because the
  // link cannot reach its data phase within the short copy burst.
  always_ff @(posedge sys_clk) begin
    if (wc.copy_we && page_mask_r[wc.idx]) begin
      mem[{wr_page_hi, wc.idx}] <= page_buf[wc.idx];
    end
  end
endmodule : sece_engine

// >>> sim/sece_checker.sv
`timescale 1ns/1ns

module sece_checker #(
  parameter int unsigned WRITE_CYCLES = 64
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic serial_clock,
  input wire logic select_n,
  input wire logic serial_in,
  input wire logic pause_n,
  input wire logic write_protect_n,
  input wire logic serial_out,
  input wire logic serial_out_oe
);
  // --------------------------------------------------------------------------
  // Frame tracking
  // --------------------------------------------------------------------------
  logic [4:0] bit_cnt_r;
  logic [7:0] op_r;
  logic is_stat_rd;
  logic is_arr_rd;
  logic no_drive_op;

  // The count folds back to 24 so that its low three bits keep the bit phase.
  always_ff @(posedge serial_clock or posedge select_n) begin
    if (select_n) begin
      bit_cnt_r <= 5'h0;
    end else if (pause_n) begin
      bit_cnt_r <= (bit_cnt_r == 5'h1f) ? 5'h18 : bit_cnt_r + 5'h1;
    end
  end

  always_ff @(posedge serial_clock) begin
    if (pause_n && bit_cnt_r < 5'h8) begin
      op_r <= {op_r[6:0], serial_in};
    end
  end

  assign is_stat_rd = op_r[7:4] == 4'h0 && op_r[2:0] == 3'h5;
  assign is_arr_rd = op_r[7:4] == 4'h0 && op_r[2:0] == 3'h3;
  assign no_drive_op = !is_stat_rd && !is_arr_rd;

  sequence s_status_high_bits;
    is_stat_rd && bit_cnt_r >= 5'h8 && bit_cnt_r[2:0] < 3'h4;
  endsequence

  sequence s_status_data;
    is_stat_rd && bit_cnt_r >= 5'h8 && pause_n;
  endsequence

  chk_opcode_quiet: assert property (
    @(posedge serial_clock) disable iff (!rst_n)
    bit_cnt_r < 5'h8 |-> !serial_out_oe) else $error("output driven during opcode");
  chk_no_drive_op: assert property (
    @(posedge serial_clock) disable iff (!rst_n)
    (bit_cnt_r >= 5'h8 && no_drive_op) |-> !serial_out_oe) else $error("output on silent op");
  chk_read_addr_quiet: assert property (
    @(posedge serial_clock) disable iff (!rst_n)
    (is_arr_rd && bit_cnt_r < 5'h10) |-> !serial_out_oe) else $error("read drove early");
  chk_status_drives: assert property (
    @(posedge serial_clock) disable iff (!rst_n)
    s_status_data |-> serial_out_oe) else $error("status read not driven");
  chk_status_top_zero: assert property (
    @(posedge serial_clock) disable iff (!rst_n)
    s_status_high_bits |-> !serial_out) else $error("status bits 7 to 4 not zero");
  chk_oe_deselect: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    select_n |-> !serial_out_oe) else $error("driving while deselected");
  chk_out_on_fall: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    $changed(serial_out) |-> !serial_clock) else $error("output moved with clock high");
  chk_oe_rise_low: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    $rose(serial_out_oe) |-> (!serial_clock && !select_n)) else $error("enable rose badly");
endmodule : sece_checker

bind sece_engine sece_checker #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (
  .sys_clk(sys_clk),
  .rst_n(rst_n),
  .serial_clock(serial_clock),
  .select_n(select_n),
  .serial_in(serial_in),
  .pause_n(pause_n),
  .write_protect_n(write_protect_n),
  .serial_out(serial_out),
  .serial_out_oe(serial_out_oe)
);

// >>> sim/sece_host.sv
`timescale 1ns/1ns

module sece_host (
  output logic select_n,
  output logic serial_clock,
  output logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_oe
);
  // --------------------------------------------------------------------------
  // Controller frames
  // --------------------------------------------------------------------------
  logic [7:0] txq[$];
  logic [7:0] rxq[$];
  logic drove;

  initial begin
    select_n = 1'b1;
    serial_clock = 1'b0;
    serial_in = 1'b0;
    drove = 1'b0;
  end

  // The clock rests low between frames; data in is inverted on release so
  // that nothing can lean on a stale level.
  task automatic run(input int n_rx);
    logic [7:0] b;
    logic [7:0] r;
    int n;
    rxq.delete();
    drove = 1'b0;
    n = txq.size() + n_rx;
    select_n = 1'b0;
    #32;
    for (int k = 0; k < n; k++) begin
      b = (k < txq.size()) ? txq[k] : 8'h00;
      for (int i = 7; i >= 0; i--) begin
        serial_in = b[i];
        #32 serial_clock = 1'b1;
        r[i] = serial_out_oe ? serial_out : ~serial_out;
        drove = drove | serial_out_oe;
        #32 serial_clock = 1'b0;
      end
      if (k >= txq.size()) rxq.push_back(r);
    end
    select_n = 1'b1;
    serial_in = ~serial_in;
    txq.delete();
    #202;
  endtask : run
endmodule : sece_host

// >>> sim/test_serial_eeprom_command_engine.sv
`timescale 1ns/1ns

module test_serial_eeprom_command_engine;
  logic sys_clk;
  logic rst_n;
  logic pause_n;
  logic write_protect_n;
  logic select_n;
  logic serial_clock;
  logic serial_in;
  logic serial_out;
  logic serial_out_oe;
  logic [7:0] st;
  int failures = 0;
  int check_count = 0;
  int cycles = 0;

  sece_engine #(.WRITE_CYCLES(1000)) dut (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .serial_clock(serial_clock),
    .select_n(select_n),
    .serial_in(serial_in),
    .pause_n(pause_n),
    .write_protect_n(write_protect_n),
    .serial_out(serial_out),
    .serial_out_oe(serial_out_oe)
  );

  sece_host host (
    .select_n(select_n),
    .serial_clock(serial_clock),
    .serial_in(serial_in),
    .serial_out(serial_out),
    .serial_out_oe(serial_out_oe)
  );

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // --------------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk8

  task automatic cmd(input logic [7:0] o);
    host.txq.push_back(o);
    host.run(0);
  endtask : cmd

  task automatic rd_status(output logic [7:0] s);
    host.txq.push_back(8'h0d);
    host.run(2);
    s = host.rxq[0];
  endtask : rd_status

  task automatic wr_arr(input logic [8:0] a, input logic [7:0] d0, input logic [7:0] d1,
                        input int n);
    host.txq.push_back({4'h0, a[8], 3'h2});
    host.txq.push_back(a[7:0]);
    host.txq.push_back(d0);
    if (n > 1) host.txq.push_back(d1);
    host.run(0);
  endtask : wr_arr

  task automatic rd_arr(input logic [8:0] a, input int n);
    host.txq.push_back({4'h0, a[8], 3'h3});
    host.txq.push_back(a[7:0]);
    host.run(n);
  endtask : rd_arr

  // Polls the busy bit by status read; array reads and writes are refused while a cycle runs.
  task automatic wait_idle();
    for (int i = 0; i < 20; i++) begin
      rd_status(st);
      if (st[0] === 1'b0) break;
    end
  endtask : wait_idle

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 50000) begin
      failures++;
      wrap_up();
    end
  end

  // --------------------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------------------
  initial begin
    rst_n = 1'b1;
    pause_n = 1'b1;
    write_protect_n = 1'b1;
    #1 rst_n = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1 host.run(0);
    rd_status(st); chk8(st, 8'h00);
    cmd(8'h0e); rd_status(st); chk8(st, 8'h02);
    cmd(8'h04); rd_status(st); chk8(st, 8'h00);
    $display("test latch done");
    cmd(8'h06); wr_arr(9'h000, 8'h5a, 8'h00, 1); wait_idle();
    cmd(8'h06); wr_arr(9'h1ff, 8'ha5, 8'h3c, 2);
    rd_arr(9'h000, 1); chk8({7'h0, host.drove}, 8'h00);
    rd_status(st); chk8(st, 8'h03);
    chk8(host.rxq[1], 8'h03);
    wait_idle(); chk8(st, 8'h00);
    rd_arr(9'h1ff, 2); chk8(host.rxq[0], 8'ha5);
    chk8(host.rxq[1], 8'h5a);
    rd_arr(9'h1e0, 1); chk8(host.rxq[0], 8'h3c);
    wr_arr(9'h000, 8'h11, 8'h00, 1); rd_status(st); chk8(st, 8'h00);
    $display("test array done");
    cmd(8'h06);
    @(posedge sys_clk);
    #1 write_protect_n = 1'b0;
    rd_status(st); chk8(st, 8'h00);
    cmd(8'h06); rd_status(st); chk8(st, 8'h00);
    @(posedge sys_clk);
    #1 write_protect_n = 1'b1;
    $display("test protect pin done");
    cmd(8'h06); host.txq.push_back(8'h01); host.txq.push_back(8'h8f); host.run(0);
    rd_status(st); chk8(st, 8'h03);
    wait_idle(); chk8(st, 8'h0c);
    cmd(8'h06); wr_arr(9'h000, 8'h22, 8'h00, 1); rd_status(st); chk8(st, 8'h0e);
    rd_arr(9'h000, 1); chk8(host.rxq[0], 8'h5a);
    cmd(8'h06); host.txq.push_back(8'h09); host.txq.push_back(8'h04); host.run(0);
    wait_idle(); chk8(st, 8'h04);
    cmd(8'h06); wr_arr(9'h17f, 8'h77, 8'h00, 1); wait_idle();
    rd_arr(9'h17f, 1); chk8(host.rxq[0], 8'h77);
    cmd(8'h06); wr_arr(9'h180, 8'h66, 8'h00, 1); rd_status(st); chk8(st, 8'h06);
    $display("test block protect done");
    host.txq.push_back(8'h07); host.txq.push_back(8'h05); host.run(1);
    chk8({7'h0, host.drove}, 8'h00);
    host.txq.push_back(8'h15); host.txq.push_back(8'h05); host.run(1);
    chk8({7'h0, host.drove}, 8'h00);
    $display("test bad opcode done");
    // Pausing over the first data rise repeats bit 7 of 0x06 and shows one
    // undriven bit, which the host reads back as the inverse.
    fork
      rd_status(st);
      begin
        #560 pause_n = 1'b0;
        #30 chk8({7'h0, serial_out_oe}, 8'h00);
        #34 pause_n = 1'b1;
      end
    join
    chk8(host.rxq[0], 8'h83);
    $display("test pause done");
    wrap_up();
  end
endmodule : test_serial_eeprom_command_engine
